// ===== design/adr_pkg.sv
// Package for the decimation rate and fast temperature sequencer.
// Assumes one 25 MHz clock and a simple strobe register port.
package adr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADR_FILTER_SETUP_OFS  = 8'h00;
  localparam logic [7:0] ADR_CONV_CONFIG_OFS   = 8'h04;
  localparam logic [7:0] ADR_OP_SELECT_OFS     = 8'h08;
  localparam logic [7:0] ADR_CUR_CTRL_OFS      = 8'h0C;
  localparam logic [7:0] ADR_VOLT_CTRL_OFS     = 8'h10;
  localparam logic [7:0] ADR_REF_PD_OFS        = 8'h14;
  localparam logic [7:0] ADR_STATUS_OFS        = 8'h18;
  localparam logic [7:0] ADR_RESULT_OFS        = 8'h1C;

  // ==========================================================================
  // Field positions and reset values
  localparam int ADR_DEC_LSB      = 0;
  localparam int ADR_DEC_MSB      = 6;
  localparam int ADR_AVG_LSB      = 8;
  localparam int ADR_AVG_MSB      = 13;
  localparam int ADR_RAVG_BIT     = 14;
  localparam int ADR_CHOP_BIT     = 15;
  localparam int ADR_QUARTIC_BIT  = 16;
  localparam int ADR_FASTT_BIT    = 0;
  localparam int ADR_LOWPWR_BIT   = 0;
  localparam int ADR_CUR_EN_BIT   = 1;
  localparam int ADR_VOLT_EN_BIT  = 2;
  localparam int ADR_SEL_LSB      = 0;
  localparam int ADR_SEL_MSB      = 2;
  localparam int ADR_DIAG_LSB     = 4;
  localparam int ADR_DIAG_MSB     = 5;
  localparam int ADR_TEMP_SEL_BIT = 3;
  localparam logic [31:0] ADR_FILTER_RST = 32'h0000_0007;
  localparam logic [31:0] ADR_OP_RST     = 32'h0000_0006;
  localparam logic [31:0] ADR_REF_PD_RST = 32'h0000_0001;
  localparam logic [6:0]  ADR_QUARTIC_DEC_MAX = 7'h0F;

  // Current channel sources: shorted, supply over 136, auxiliary, reference difference.
  localparam logic [2:0] ADR_CUR_SHORT = 3'h1;
  localparam logic [2:0] ADR_CUR_SUPPLY136 = 3'h2;
  localparam logic [2:0] ADR_CUR_AUX   = 3'h3;
  localparam logic [2:0] ADR_CUR_REFDIF = 3'h4;
  // Voltage channel sources: auxiliary, junction to ground, shorted junction.
  localparam logic [2:0] ADR_VOLT_AUX  = 3'h1;
  localparam logic [2:0] ADR_VOLT_VBE  = 3'h2;
  localparam logic [2:0] ADR_VOLT_SHORT = 3'h3;

  // ==========================================================================
  // Timing
  localparam int ADR_CLK_HZ        = 25_000_000;
  localparam int ADR_MOD_NORMAL_HZ = 512_000;
  localparam int ADR_MOD_LOWPWR_HZ = 128_000;
  localparam int ADR_MOD_NORMAL_DIV = ADR_CLK_HZ / ADR_MOD_NORMAL_HZ;
  localparam int ADR_MOD_LOWPWR_DIV = ADR_CLK_HZ / ADR_MOD_LOWPWR_HZ;
  localparam int ADR_EXTRA_US      = 60;
  localparam int ADR_EXTRA_CYC     = (ADR_EXTRA_US * (ADR_CLK_HZ / 1_000_000));
  localparam int ADR_CHOP_ADD      = 3;
  localparam int ADR_AVG_ADD       = 3;
  localparam int ADR_TICKS_PER_DEC = 64;
  localparam int ADR_QUARTIC_CHOP_MUL = 4;
  localparam logic [2:0] ADR_SWITCH_SETTLE = 3'h3;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } adr_bus_req_t;

  typedef enum logic [1:0] {ADR_ST_IDLE, ADR_ST_EXTRA, ADR_ST_RUN} adr_state_t;

endpackage : adr_pkg

// ===== design/adr_core.sv
// Decimation rate, settling and fast temperature sequencer for two converters.
// Assumes a 25 MHz clock, an asynchronous active low reset and a same-clock
// register master with one-cycle strobes.
//
// Notes on behaviour
// - Cubic rate is mod/(64*(dec+1)), times (3+avg) if averaging, plus 3 with chop.
// - Cubic settling periods: 3, 4 running avg, 1 avg, 2 both, 2 chop.
// - Quartic rate mod/(64*(dec+1)); settle 4 or 5; chop: times 4 plus 3, settle 2.
// - Modulator tick is 512 kHz normally, 128 kHz in low power.
// - About 60 us extra per converter before the first result appears.
// - Quartic mode clamps decimation above 0x0F to 0x0F.
// - Voltage and temperature input switch settles after three conversions.
// - Fast temperature request executes one conversion period after it is set.
// - Fifth result flags temperature and current; two current-only; then voltage resumes.
// - Current input select offers short, supply/136, auxiliary, reference difference.
// - Each channel has two 50 uA test current sources under its control bits.
// - Voltage input select offers auxiliary, junction voltage and shorted junction.
// - Reference buffer power-down bit is set at reset and powers buffer down.
// - Reference changes leave converter operation untouched.
// - Decimation bits 6:0, averaging bits 13:8, chop bit 15.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module adr_core
  import adr_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               arst_n_in,
  input  wire adr_pkg::adr_bus_req_t bus_in,
  output logic [31:0]             rdata_out,
  output logic                    current_result_ready_out,
  output logic                    voltage_result_ready_out,
  output logic                    temperature_result_ready_out,
  output logic [2:0]              current_input_select_out,
  output logic [2:0]              voltage_input_select_out,
  output logic [3:0]              test_current_enable_out,
  output logic                    temp_input_active_out,
  output logic                    ref_buffer_powerdown_out
);
  import adr_pkg::*;

  // ==========================================================================
  // Registers
  logic [31:0] filter_setup_q;
  logic        fast_temp_q;
  logic [2:0]  converter_op_select_q;
  logic [7:0]  cur_ctrl_q;
  logic [7:0]  volt_ctrl_q;
  logic        ref_pd_q;
  logic [31:0] rdata_q;

  wire wr_filter = bus_in.wr && (bus_in.addr == ADR_FILTER_SETUP_OFS);
  wire wr_cfg    = bus_in.wr && (bus_in.addr == ADR_CONV_CONFIG_OFS);
  wire wr_op     = bus_in.wr && (bus_in.addr == ADR_OP_SELECT_OFS);
  wire wr_cur    = bus_in.wr && (bus_in.addr == ADR_CUR_CTRL_OFS);
  wire wr_volt   = bus_in.wr && (bus_in.addr == ADR_VOLT_CTRL_OFS);
  wire wr_ref    = bus_in.wr && (bus_in.addr == ADR_REF_PD_OFS);
  // A filter, mode or current-control write restarts settling like a power-on.
  wire reconfig  = wr_filter || wr_op || wr_cur;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      filter_setup_q        <= ADR_FILTER_RST;
      fast_temp_q           <= 1'b0;
      converter_op_select_q <= ADR_OP_RST[2:0];
      cur_ctrl_q            <= 8'h00;
      volt_ctrl_q           <= 8'h00;
      ref_pd_q              <= ADR_REF_PD_RST[0];
    end
    else
    begin
      if (wr_filter)
        filter_setup_q <= {15'h0000, bus_in.wdata[16:0]};
      if (wr_cfg)
        fast_temp_q <= bus_in.wdata[ADR_FASTT_BIT];
      if (wr_op)
        converter_op_select_q <= bus_in.wdata[2:0];
      if (wr_cur)
        cur_ctrl_q <= bus_in.wdata[7:0];
      if (wr_volt)
        volt_ctrl_q <= bus_in.wdata[7:0];
      if (wr_ref)
        ref_pd_q <= bus_in.wdata[0];
    end
  end

  // ==========================================================================
  // Rate arithmetic
  wire [6:0] dec_raw  = filter_setup_q[ADR_DEC_MSB:ADR_DEC_LSB];
  wire [5:0] avg      = filter_setup_q[ADR_AVG_MSB:ADR_AVG_LSB];
  wire       ravg     = filter_setup_q[ADR_RAVG_BIT];
  wire       chop     = filter_setup_q[ADR_CHOP_BIT];
  wire       quartic  = filter_setup_q[ADR_QUARTIC_BIT];
  wire [6:0] dec_eff  = (quartic && dec_raw > ADR_QUARTIC_DEC_MAX) ? ADR_QUARTIC_DEC_MAX : dec_raw;
  wire       avg_on   = !quartic && (avg != 6'h00);

  // Conversion length in modulator ticks.
  function automatic logic [19:0] conv_ticks(input logic [6:0] d, input logic [5:0] a,
                                             input logic av, input logic q, input logic ch);
    logic [19:0] base;
    base = 20'(ADR_TICKS_PER_DEC) * (20'(d) + 20'h00001);
    if (q)
      conv_ticks = ch ? (base * 20'(ADR_QUARTIC_CHOP_MUL) + 20'(ADR_CHOP_ADD)) : base;
    else
    begin
      if (av)
        base = base * (20'(ADR_AVG_ADD) + 20'(a));
      conv_ticks = ch ? base + 20'(ADR_CHOP_ADD) : base;
    end
  endfunction

  function automatic logic [2:0] settle_periods(input logic av, input logic rv,
                                                input logic q, input logic ch);
    if (ch)
      settle_periods = 3'h2;
    else if (q)
      settle_periods = rv ? 3'h5 : 3'h4;
    else if (av)
      settle_periods = rv ? 3'h2 : 3'h1;
    else
      settle_periods = rv ? 3'h4 : 3'h3;
  endfunction

  wire [19:0] conv_len = conv_ticks(dec_eff, avg, avg_on, quartic, chop);
  wire [2:0]  settle_n = settle_periods(avg_on, ravg, quartic, chop);

  // ==========================================================================
  // Modulator tick divider
  logic [7:0] div_q;
  wire        lowpwr   = converter_op_select_q[ADR_LOWPWR_BIT];
  wire [7:0]  div_end  = lowpwr ? 8'(ADR_MOD_LOWPWR_DIV - 1) : 8'(ADR_MOD_NORMAL_DIV - 1);
  wire        mod_tick = (div_q >= div_end);

  // ==========================================================================
  // Conversion sequencer
  wire cur_en  = converter_op_select_q[ADR_CUR_EN_BIT];
  wire volt_en = converter_op_select_q[ADR_VOLT_EN_BIT];
  wire any_en  = cur_en || volt_en;
  wire [11:0] extra_len = (cur_en && volt_en) ? 12'(2 * ADR_EXTRA_CYC) : 12'(ADR_EXTRA_CYC);

  adr_state_t  state_q;
  logic [19:0] tick_cnt_q;
  logic [11:0] extra_cnt_q;
  logic [2:0]  settle_cnt_q;
  logic [2:0]  volt_settle_q;
  logic        temp_sel_q;
  logic [2:0]  fast_seq_q;
  logic        cur_rdy_q;
  logic        volt_rdy_q;
  logic        temp_rdy_q;

  wire conv_done = (state_q == ADR_ST_RUN) && mod_tick && (tick_cnt_q >= conv_len - 20'h00001);
  wire settled   = (settle_cnt_q >= settle_n);
  wire want_temp = volt_ctrl_q[ADR_TEMP_SEL_BIT];
  // Fast sequence: 1 armed for temperature, 2 and 3 current-only results, 4 voltage resumes.
  wire fast_arm  = fast_temp_q && (fast_seq_q == 3'h0) && conv_done;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      div_q <= 8'h00;
    else
      div_q <= mod_tick ? 8'h00 : div_q + 8'h01;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_q     <= ADR_ST_IDLE;
      tick_cnt_q  <= 20'h00000;
      extra_cnt_q <= 12'h000;
      settle_cnt_q <= 3'h0;
    end
    else if (reconfig || !any_en)
    begin
      state_q      <= any_en || wr_op ? ADR_ST_EXTRA : ADR_ST_IDLE;
      tick_cnt_q   <= 20'h00000;
      extra_cnt_q  <= 12'h000;
      settle_cnt_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        ADR_ST_IDLE:
          state_q <= ADR_ST_EXTRA;
        ADR_ST_EXTRA:
        begin
          extra_cnt_q <= extra_cnt_q + 12'h001;
          if (extra_cnt_q >= extra_len - 12'h001)
            state_q <= ADR_ST_RUN;
        end
        ADR_ST_RUN:
          if (mod_tick)
          begin
            if (conv_done)
            begin
              tick_cnt_q <= 20'h00000;
              if (!settled)
                settle_cnt_q <= settle_cnt_q + 3'h1;
            end
            else
              tick_cnt_q <= tick_cnt_q + 20'h00001;
          end
        default:
          state_q <= ADR_ST_IDLE;
      endcase
    end
  end

  // Voltage channel input switching and fast temperature steps.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      volt_settle_q <= 3'h0;
      temp_sel_q    <= 1'b0;
      fast_seq_q    <= 3'h0;
    end
    else if (reconfig || !fast_temp_q && fast_seq_q != 3'h0 && fast_seq_q < 3'h2)
      fast_seq_q <= 3'h0;
    else if (conv_done)
    begin
      if (fast_arm)
        fast_seq_q <= 3'h1;
      else if (fast_seq_q != 3'h0 && fast_seq_q < 3'h4)
        fast_seq_q <= fast_seq_q + 3'h1;
      else if (fast_seq_q == 3'h4 && !fast_temp_q)
        fast_seq_q <= 3'h0;
      if (want_temp != temp_sel_q)
      begin
        temp_sel_q    <= want_temp;
        volt_settle_q <= 3'h1;
      end
      else if (volt_settle_q != 3'h0 && volt_settle_q < ADR_SWITCH_SETTLE)
        volt_settle_q <= volt_settle_q + 3'h1;
      else
        volt_settle_q <= 3'h0;
    end
  end

  wire settle_ok = settled || (settle_cnt_q == settle_n - 3'h1);
  wire volt_ok   = (volt_settle_q == 3'h0) || (volt_settle_q == ADR_SWITCH_SETTLE);
  wire temp_slot = (fast_seq_q == 3'h1);
  wire gap_slot  = (fast_seq_q == 3'h2) || (fast_seq_q == 3'h3);

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cur_rdy_q  <= 1'b0;
      volt_rdy_q <= 1'b0;
      temp_rdy_q <= 1'b0;
    end
    else
    begin
      cur_rdy_q  <= conv_done && settle_ok && cur_en;
      volt_rdy_q <= conv_done && settle_ok && volt_en && volt_ok && !temp_slot && !gap_slot;
      temp_rdy_q <= conv_done && settle_ok && volt_en && temp_slot;
    end
  end

  // ==========================================================================
  // Read port
  logic [31:0] rd_mux;
  always_comb
  begin
    case (bus_in.addr)
      ADR_FILTER_SETUP_OFS: rd_mux = filter_setup_q;
      ADR_CONV_CONFIG_OFS:  rd_mux = {31'h0, fast_temp_q};
      ADR_OP_SELECT_OFS:    rd_mux = {29'h0, converter_op_select_q};
      ADR_CUR_CTRL_OFS:     rd_mux = {24'h0, cur_ctrl_q};
      ADR_VOLT_CTRL_OFS:    rd_mux = {24'h0, volt_ctrl_q};
      ADR_REF_PD_OFS:       rd_mux = {31'h0, ref_pd_q};
      ADR_STATUS_OFS:       rd_mux = {24'h0, fast_seq_q, settle_cnt_q, state_q};
      ADR_RESULT_OFS:       rd_mux = {12'h000, conv_len};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= bus_in.rd ? rd_mux : 32'h0000_0000;
  end

  // Outputs come straight from flip-flops.
  assign rdata_out                    = rdata_q;
  assign current_result_ready_out     = cur_rdy_q;
  assign voltage_result_ready_out     = volt_rdy_q;
  assign temperature_result_ready_out = temp_rdy_q;
  assign current_input_select_out     = cur_ctrl_q[ADR_SEL_MSB:ADR_SEL_LSB];
  assign voltage_input_select_out     = volt_ctrl_q[ADR_SEL_MSB:ADR_SEL_LSB];
  assign test_current_enable_out      = {volt_ctrl_q[ADR_DIAG_MSB:ADR_DIAG_LSB], cur_ctrl_q[ADR_DIAG_MSB:ADR_DIAG_LSB]};
  assign temp_input_active_out        = temp_sel_q;
  assign ref_buffer_powerdown_out     = ref_pd_q;

  // ==========================================================================
  // Checks
  sequence s_temp_flag;
    temperature_result_ready_out;
  endsequence

  // The first two conversions after an input switch still carry the old input.
  sequence s_switch_step;
    conv_done && (volt_settle_q == 3'h1 || volt_settle_q == 3'h2);
  endsequence

  AST_TEMP_NOT_VOLT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_temp_flag |-> !voltage_result_ready_out) else $error("temperature and voltage flagged together");
  AST_TEMP_WITH_CUR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (s_temp_flag and cur_en) |-> current_result_ready_out) else $error("temperature without current flag");
  AST_RDY_PULSE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    current_result_ready_out |=> !current_result_ready_out) else $error("ready longer than one cycle");
  AST_QUARTIC_CLAMP: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    quartic |-> dec_eff <= ADR_QUARTIC_DEC_MAX) else $error("quartic decimation not clamped");
  AST_MOD_RATE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    mod_tick && !lowpwr |=> !mod_tick [*8]) else $error("modulator tick too fast");
  AST_REF_KEEPS_MODE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    wr_ref && !reconfig |=> $stable(converter_op_select_q)) else $error("reference write changed mode");
  AST_EXTRA_DELAY: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    state_q == ADR_ST_EXTRA && extra_cnt_q == 12'h000 && !reconfig && any_en |=> state_q != ADR_ST_RUN)
    else $error("first result without extra delay");
  AST_CHOP_ADD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    chop && !quartic && !avg_on |-> conv_len == 20'(64) * (20'(dec_eff) + 20'h00001) + 20'h00003)
    else $error("chop divisor wrong");
  AST_SETTLE_CHOP: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    chop |-> settle_n == 3'h2) else $error("chop settling not two periods");
  AST_FAST_START: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    fast_arm && !reconfig |=> fast_seq_q == 3'h1) else $error("fast request not armed");
  AST_SWITCH_QUIET: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_switch_step |=> !voltage_result_ready_out) else $error("voltage flagged while input settles");

endmodule // adr_core

// ===== sim/adr_host_model.sv
// Register master model that stands in for the host software.
// Assumes the shared clock; strobes change just after a rising edge.
`timescale 1ns/1ps
module adr_host_model
  import adr_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic [31:0]      rdata_in,
  output adr_pkg::adr_bus_req_t bus_out
);
  import adr_pkg::*;

  // ==========================================================================
  // Bus cycles
  initial bus_out = '0;

  // Released address and data show the inverse, so a stale value never matches.
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_out <= '{addr: ~a, wdata: 32'hFFFF_FFFF, wr: 1'b0, rd: 1'b0};
    @(posedge clk_in);
    d = rdata_in;
  endtask

endmodule // adr_host_model

// ===== sim/tb_top.sv
// Self-checking bench for the decimation rate and fast temperature sequencer.
// Assumes adr_pkg, adr_core and adr_host_model are compiled before it.
`timescale 1ns/1ps
module tb_top;
  import adr_pkg::*;

  // ==========================================================================
  // Signals
  logic         clk_in;
  logic         arst_n_in;
  adr_bus_req_t bus_in;
  logic [31:0]  rdata_out;
  logic         cur_rdy;
  logic         volt_rdy;
  logic         temp_rdy;
  logic [2:0]   cur_sel;
  logic [2:0]   volt_sel;
  logic [3:0]   test_cur;
  logic         temp_act;
  logic         ref_pd;
  int           bad_count = 0;
  int           total_checks = 0;
  int           cyc = 0;
  logic [31:0]  seed;
  logic [31:0]  rd_val;

  adr_core i_adr_core (
    .clk_in                       (clk_in),
    .arst_n_in                    (arst_n_in),
    .bus_in                       (bus_in),
    .rdata_out                    (rdata_out),
    .current_result_ready_out     (cur_rdy),
    .voltage_result_ready_out     (volt_rdy),
    .temperature_result_ready_out (temp_rdy),
    .current_input_select_out     (cur_sel),
    .voltage_input_select_out     (volt_sel),
    .test_current_enable_out      (test_cur),
    .temp_input_active_out        (temp_act),
    .ref_buffer_powerdown_out     (ref_pd)
  );

  adr_host_model i_adr_host_model (
    .clk_in   (clk_in),
    .rdata_in (rdata_out),
    .bus_out  (bus_in)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  always @(posedge clk_in) cyc <= cyc + 1;

  // ==========================================================================
  // Helpers
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int exp_len(input logic [31:0] f);
    int d;
    int n;
    d = int'(f[6:0]);
    if (f[16])
    begin
      if (d > 15) d = 15;
      n = 64 * (d + 1);
      if (f[15]) n = n * 4 + 3;
    end
    else
    begin
      n = 64 * (d + 1);
      if (f[13:8] != 6'h00) n = n * (3 + int'(f[13:8]));
      if (f[15]) n = n + 3;
    end
    return n;
  endfunction

  function automatic int exp_settle(input logic [31:0] f);
    if (f[15]) return 2;
    if (f[16]) return f[14] ? 5 : 4;
    if (f[13:8] != 6'h00) return f[14] ? 2 : 1;
    return f[14] ? 4 : 3;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_adr_host_model.write_reg(a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
    i_adr_host_model.read_reg(a, rd_val);
    check(rd_val, e, m);
  endtask

  // Waits for a current result flag; a spent bound ends the run.
  task automatic wait_cur(input int lim, output int t);
    for (int i = 0; i < lim; i++)
    begin
      @(posedge clk_in);
      #1;
      if (cur_rdy === 1'b1)
      begin
        t = cyc;
        return;
      end
    end
    bad_count++;
    $display("unexpected at %0t: no result flag", $time);
    wrap_up();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic mux_run();
    logic [31:0] r;
    logic [2:0]  cs;
    logic [2:0]  vs;
    for (int i = 0; i < 8; i++)
    begin
      r = xs();
      cs = 3'(i % 4 + 1);
      vs = 3'(i % 3 + 1);
      wr(ADR_CUR_CTRL_OFS, {26'h0, r[1:0], 1'b0, cs});
      wr(ADR_VOLT_CTRL_OFS, {26'h0, r[3:2], r[4], vs});
      @(posedge clk_in);
      #1;
      check(32'(cur_sel), 32'(cs), "current select");
      check(32'(volt_sel), 32'(vs), "voltage select");
      check(32'(test_cur), 32'({r[3:2], r[1:0]}), "test currents");
      // The converter follows the input select only at a conversion end, and none ends here.
      check(32'(temp_act), 32'h0, "temperature input");
    end
  endtask

  task automatic rate_run();
    logic [31:0] r;
    logic [31:0] f;
    for (int i = 0; i < 16; i++)
    begin
      r = xs();
      if (r[0])
        f = {15'h0, 1'b1, r[1], r[2], 7'h0, r[9:3]};
      else
        f = {16'h0, r[1], r[2], 6'(r[15:10] % 63), 1'b0, 7'(r[20:16] % 31 + 1)};
      wr(ADR_FILTER_SETUP_OFS, f);
      rdchk(ADR_RESULT_OFS, 32'(exp_len(f)), "conversion length");
    end
  endtask

  // With sw set both converters run and the voltage input is switched once settled.
  task automatic settle_run(input logic [31:0] f, input logic sw);
    int   t0;
    int   t1;
    int   t2;
    int   t3;
    int   p;
    int   e;
    logic tw;
    p = exp_len(f) * ADR_MOD_NORMAL_DIV;
    e = (sw ? 2 : 1) * ADR_EXTRA_CYC + exp_settle(f) * p;
    wr(ADR_OP_SELECT_OFS, sw ? 32'h6 : 32'h2);
    wr(ADR_FILTER_SETUP_OFS, f);
    t0 = cyc;
    wait_cur(e + 2 * p, t1);
    tw = ~temp_act;
    if (sw) wr(ADR_VOLT_CTRL_OFS, {28'h0, tw, 3'h1});
    wait_cur(2 * p, t2);
    check(32'(t2 - t1), 32'(p), "period");
    check(32'((t1 - t0 > e - p / 2) && (t1 - t0 < e + p / 2)), 32'h1, "first result");
    if (sw)
    begin
      check(32'(volt_rdy), 32'h1, "voltage before switch");
      for (int k = 1; k <= 3; k++)
      begin
        wait_cur(2 * p, t3);
        check(32'(volt_rdy), 32'(k == 3), "voltage after switch");
      end
      check(32'(temp_act), 32'(tw), "switched input");
    end
  endtask

  task automatic fast_run();
    int   t;
    int   tp;
    logic v;
    logic tr;
    tp = 0;
    wr(ADR_CONV_CONFIG_OFS, 32'h0);
    wr(ADR_OP_SELECT_OFS, 32'h6);
    wr(ADR_FILTER_SETUP_OFS, 32'h1);
    for (int n = 1; n <= 8; n++)
    begin
      wait_cur(40000, t);
      v = volt_rdy;
      tr = temp_rdy;
      if (n > 1) check(32'(t - tp), 32'(128 * ADR_MOD_NORMAL_DIV), "spacing");
      tp = t;
      check(32'(v), 32'(n < 5 || n == 8), "voltage flag");
      check(32'(tr), 32'(n == 5), "temperature flag");
      if (n == 3) wr(ADR_CONV_CONFIG_OFS, 32'h1);
      if (n == 4) i_adr_host_model.read_reg(ADR_RESULT_OFS, rd_val);
      if (n == 5) wr(ADR_CONV_CONFIG_OFS, 32'h0);
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    arst_n_in = 1'b0;
    seed = 32'h3529;
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rdchk(ADR_FILTER_SETUP_OFS, ADR_FILTER_RST, "filter reset");
    rdchk(ADR_OP_SELECT_OFS, ADR_OP_RST, "mode reset");
    rdchk(ADR_REF_PD_OFS, ADR_REF_PD_RST, "reference reset");
    rdchk(8'h40, 32'h0, "unmapped read");
    check(32'(ref_pd), 32'h1, "reference pin");
    wr(ADR_REF_PD_OFS, 32'h0);
    @(posedge clk_in);
    #1;
    check(32'(ref_pd), 32'h0, "reference pin off");
    rdchk(ADR_OP_SELECT_OFS, ADR_OP_RST, "mode kept");
    $display("test registers done");
    mux_run();
    $display("test input select done");
    rate_run();
    $display("test rates done");
    settle_run(32'h0000_8000, 1'b0);
    settle_run(32'h0001_0000, 1'b1);
    $display("test settling done");
    fast_run();
    $display("test fast temperature done");
    wrap_up();
  end

endmodule // tb_top
